// ==== dea_pkg.sv ====
// constants shared by the data eeprom access controller and its array
// assumes a 100 MHz system clock and an avalon-mm slave with byte addresses
//
// How it works
// [RULE_01] capture off: array read answers like rom
// [RULE_02] capture on: writes fill one of 16 latches
// [RULE_03] program start writes latches into last row
// [RULE_04] software keeps latched writes inside one row
// [RULE_05] cycle end clears both bits, then interrupt
// [RULE_06] vector fetch clears pending completion interrupt
// [RULE_07] latches clear at end/fall; rewrites and together
// [RULE_08] latch contents never readable
// [RULE_09] wait entered only once no cycle runs
// [RULE_10] halt aborts any running cycle at once
// [RULE_11] capture on: array read returns nothing driven
// [RULE_12] capture off: array writes are ignored
// [RULE_13] software should not break a running cycle
// [RULE_14] control register resets 00, bits 7:3 zero
// [RULE_15] capture clear by software only when idle
// [RULE_16] program start reads one throughout the cycle
// [RULE_17] erase and program chained and timed inside
// [RULE_18] cycle durations are clock-count parameters
package dea_pkg;

    // register byte addresses on the bus
    localparam logic [11:0] CSR_OFS      = 12'h02C;
    localparam logic [11:0] IRQ_STAT_OFS = 12'h030;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h034;
    // array window: address bits 11:10 equal to this value
    localparam logic [1:0]  ARRAY_SEL    = 2'h1;

    // control/status field positions and reset
    localparam int          CSR_PGM_BIT  = 0;
    localparam int          CSR_CAP_BIT  = 1;
    localparam int          CSR_IE_BIT   = 2;
    localparam logic [7:0]  CSR_RST      = 8'h00;
    localparam logic        IRQ_STAT_RST = 1'b0;
    localparam logic        IRQ_MASK_RST = 1'b1;

    // array geometry
    localparam int          LATCH_COUNT  = 16;
    localparam int          IDX_W        = 4;
    localparam int          ROW_W        = 4;
    localparam int          ARR_AW       = 8;
    localparam int          ARR_DEPTH    = 256;
    localparam logic [7:0]  LATCH_ERASED = 8'hFF;

    // cycle timing
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          ERASE_TIME_US = 1000;
    localparam int          PROG_TIME_US  = 1000;
    localparam int          ERASE_CYCLES  =
        (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          PROG_CYCLES   =
        (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W         = 24;

    // programming sequence states
    typedef enum logic [1:0] {
        PS_IDLE,
        PS_ERASE,
        PS_BURST,
        PS_PROG
    } dea_prog_e;

endpackage

// ==== dea_mem.sv ====
// byte array of the data eeprom, one write or read port
// assumes the owner arbitrates the port; read data is registered
`timescale 1ns/1ps
module dea_mem #(
    parameter int DATA_W = 8,
    parameter int DEPTH  = 256,
    parameter int AW     = 8
) (
    // clock
    input  wire logic              i_clk,
    // access port
    input  wire logic              i_we,
    input  wire logic [AW-1:0]     i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    output logic      [DATA_W-1:0] o_rdata
);

    logic [DATA_W-1:0] mem_reg [DEPTH];

    // write on strobe, read data out of a register
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_reg[i_addr] <= i_wdata;
        end
        o_rdata <= mem_reg[i_addr];
    end

endmodule // dea_mem

// ==== dea_ctrl.sv ====
// data eeprom access controller: bus slave, row latches, timed cycle
// assumes an avalon-mm master holding each request until waitrequest
// is low, and cpu wait/halt/vector-fetch strobes synchronous to clock
`timescale 1ns/1ps
module dea_ctrl #(
    parameter int ERASE_CYC = dea_pkg::ERASE_CYCLES,
    parameter int PROG_CYC  = dea_pkg::PROG_CYCLES
) (
    // clock and reset
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_SRST,
    // avalon-mm slave
    input  wire logic [11:0] I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    input  wire logic [3:0]  I_AVS_BYTEENABLE,
    output logic      [31:0] O_AVS_READDATA,
    output logic             O_AVS_WAITREQUEST,
    // cpu power and interrupt hooks
    input  wire logic        I_VECTOR_FETCH,
    input  wire logic        I_SLEEP_WAIT_INSTRUCTION,
    input  wire logic        I_HALT,
    // status outputs
    output logic             O_IRQ,
    output logic             O_EE_WAIT,
    output logic             O_EE_HALTED
);

    localparam int LC = dea_pkg::LATCH_COUNT;
    localparam int IW = dea_pkg::IDX_W;
    localparam int RW = dea_pkg::ROW_W;
    localparam int AW = dea_pkg::ARR_AW;
    localparam int CW = dea_pkg::CNT_W;

    // true when the byte address falls in the array window
    function automatic logic is_array(input logic [11:0] a);
        is_array = (a[11:10] == dea_pkg::ARRAY_SEL);
    endfunction

    // array byte index of a bus address
    function automatic logic [AW-1:0] arr_index(input logic [11:0] a);
        arr_index = a[9:2];
    endfunction

    // bus handshake state
    logic                   wait_reg;
    logic                   rd_pend_reg;
    logic [31:0]            rdata_reg;

    // control/status bits
    logic                   ie_reg;
    logic                   cap_reg;
    logic                   pgm_reg;
    logic                   cap_d_reg;

    // interrupt status and mask
    logic                   stat_reg;
    logic                   mask_reg;
    logic                   irq_reg;

    // power-mode outputs
    logic                   ee_wait_reg;
    logic                   halted_reg;

    // programming sequencer
    dea_pkg::dea_prog_e     ps_reg;
    logic [CW-1:0]          cnt_reg;
    logic [IW-1:0]          k_reg;

    // row latches
    logic [7:0]             latch_reg [LC];
    logic [LC-1:0]          valid_reg;
    logic [RW-1:0]          row_reg;

    // array port
    logic                   mem_we;
    logic [AW-1:0]          mem_addr;
    logic [7:0]             mem_rdata;

    // decode and events
    logic                   req;
    logic                   take;
    logic                   sel_csr;
    logic                   sel_stat;
    logic                   sel_mask;
    logic                   sel_arr;
    logic                   wr_en;
    logic                   csr_wr;
    logic                   arr_wr;
    logic                   arr_rd;
    logic                   stat_rd;
    logic                   mask_wr;
    logic                   start;
    logic                   sw_abort;
    logic                   abort;
    logic                   prog_done;
    logic [7:0]             csr_val;
    logic [31:0]            rd_mux;

    // address decode
    assign sel_csr  = (I_AVS_ADDRESS == dea_pkg::CSR_OFS);
    assign sel_stat = (I_AVS_ADDRESS == dea_pkg::IRQ_STAT_OFS);
    assign sel_mask = (I_AVS_ADDRESS == dea_pkg::IRQ_MASK_OFS);
    assign sel_arr  = is_array(I_AVS_ADDRESS);

    // a request is taken once; array reads wait while the burst owns the
    // array port
    assign req  = I_AVS_READ | I_AVS_WRITE;
    assign take = req && wait_reg && !rd_pend_reg
                  && !(I_AVS_READ && sel_arr
                       && ps_reg == dea_pkg::PS_BURST);

    // write strobes; only the low byte lane carries data
    assign wr_en   = take && I_AVS_WRITE && I_AVS_BYTEENABLE[0];
    assign csr_wr  = wr_en && sel_csr;
    assign mask_wr = wr_en && sel_mask;
    assign arr_wr  = wr_en && sel_arr && cap_reg && !pgm_reg; // [RULE_12]
    assign stat_rd = take && I_AVS_READ && sel_stat;
    // capture on leaves the array out of the read path
    assign arr_rd  = take && I_AVS_READ && sel_arr && !cap_reg; // [RULE_11]

    // sequencer control events
    assign start = csr_wr && I_AVS_WRITEDATA[dea_pkg::CSR_PGM_BIT]
                   && !pgm_reg && !I_HALT
                   && (cap_reg || I_AVS_WRITEDATA[dea_pkg::CSR_CAP_BIT]);
    assign sw_abort = csr_wr && pgm_reg
                      && !I_AVS_WRITEDATA[dea_pkg::CSR_PGM_BIT];
    assign abort = I_HALT || sw_abort; // [RULE_10]
    assign prog_done = (ps_reg == dea_pkg::PS_PROG) && (cnt_reg == '0)
                       && !abort;

    // register view: bits 7:3 are forced to zero
    assign csr_val = {5'h00, ie_reg, cap_reg, pgm_reg}; // [RULE_14]

    // read data selection; latches have no read path at all
    always_comb begin
        rd_mux = 32'h0000_0000; // [RULE_08]
        if (sel_csr) begin
            rd_mux = {24'h00_0000, csr_val};
        end else if (sel_stat) begin
            rd_mux = {31'h0000_0000, stat_reg};
        end else if (sel_mask) begin
            rd_mux = {31'h0000_0000, mask_reg};
        end
    end

    // array port: burst writes latched bytes, otherwise bus reads
    always_comb begin
        mem_we   = 1'b0;
        mem_addr = arr_index(I_AVS_ADDRESS);
        if (ps_reg == dea_pkg::PS_BURST) begin
            mem_we   = valid_reg[k_reg]; // [RULE_03]
            mem_addr = {row_reg, k_reg};
        end
    end

    // byte array
    dea_mem #(
        .DATA_W (8),
        .DEPTH  (dea_pkg::ARR_DEPTH),
        .AW     (AW)
    ) u_mem (
        .i_clk   (I_CLK_SYS),
        .i_we    (mem_we),
        .i_addr  (mem_addr),
        .i_wdata (latch_reg[k_reg]),
        .o_rdata (mem_rdata)
    );

    // bus handshake: waitrequest drops for one cycle per request
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            wait_reg    <= 1'b1;
            rd_pend_reg <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
        end else if (!wait_reg) begin
            wait_reg <= 1'b1;
        end else if (rd_pend_reg) begin
            // array byte arrives one cycle after its address
            rdata_reg   <= {24'h00_0000, mem_rdata}; // [RULE_01]
            rd_pend_reg <= 1'b0;
            wait_reg    <= 1'b0;
        end else if (take) begin
            // array reads keep the old word until their byte arrives
            if (arr_rd) begin
                rd_pend_reg <= 1'b1;
            end else begin
                rdata_reg <= rd_mux;
                wait_reg  <= 1'b0;
            end
        end
    end

    // interrupt enable, capture mode and program start bits
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            ie_reg  <= dea_pkg::CSR_RST[dea_pkg::CSR_IE_BIT]; // [RULE_14]
            cap_reg <= dea_pkg::CSR_RST[dea_pkg::CSR_CAP_BIT];
            pgm_reg <= dea_pkg::CSR_RST[dea_pkg::CSR_PGM_BIT];
        end else begin
            if (csr_wr) begin
                ie_reg <= I_AVS_WRITEDATA[dea_pkg::CSR_IE_BIT];
            end
            if (prog_done) begin
                // both bits drop together at cycle end
                pgm_reg <= 1'b0; // [RULE_05]
                cap_reg <= 1'b0;
            end else if (I_HALT) begin
                pgm_reg <= 1'b0; // [RULE_10]
            end else if (csr_wr) begin
                if (I_AVS_WRITEDATA[dea_pkg::CSR_CAP_BIT]) begin
                    cap_reg <= 1'b1;
                end else if (!pgm_reg) begin
                    cap_reg <= 1'b0; // [RULE_15]
                end
                if (start) begin
                    pgm_reg <= 1'b1; // [RULE_16]
                end else if (sw_abort) begin
                    pgm_reg <= 1'b0; // [RULE_13]
                end
            end
        end
    end

    // previous capture bit, for the falling-edge latch clear
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            cap_d_reg <= 1'b0;
        end else begin
            cap_d_reg <= cap_reg;
        end
    end

    // erase, burst write and program phases run back to back
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            ps_reg  <= dea_pkg::PS_IDLE;
            cnt_reg <= '0;
            k_reg   <= '0;
        end else if (abort) begin
            ps_reg  <= dea_pkg::PS_IDLE; // [RULE_10]
            cnt_reg <= '0;
            k_reg   <= '0;
        end else begin
            case (ps_reg)
                dea_pkg::PS_IDLE: begin
                    if (start) begin
                        ps_reg  <= dea_pkg::PS_ERASE;
                        cnt_reg <= CW'(ERASE_CYC - 1); // [RULE_18]
                    end
                end
                dea_pkg::PS_ERASE: begin
                    if (cnt_reg == '0) begin
                        ps_reg <= dea_pkg::PS_BURST; // [RULE_17]
                        k_reg  <= '0;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                dea_pkg::PS_BURST: begin
                    k_reg <= k_reg + 1'b1;
                    if (k_reg == IW'(LC - 1)) begin
                        ps_reg  <= dea_pkg::PS_PROG; // [RULE_17]
                        cnt_reg <= CW'(PROG_CYC - 1); // [RULE_18]
                    end
                end
                dea_pkg::PS_PROG: begin
                    if (cnt_reg == '0) begin
                        ps_reg <= dea_pkg::PS_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                default: begin
                    ps_reg <= dea_pkg::PS_IDLE;
                end
            endcase
        end
    end

    // row latches: erased state is all ones, rewrites and into it
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST || prog_done || (cap_d_reg && !cap_reg)) begin
            for (int i = 0; i < LC; i++) begin
                latch_reg[i] <= dea_pkg::LATCH_ERASED; // [RULE_07]
            end
            valid_reg <= '0;
        end else if (arr_wr) begin
            latch_reg[I_AVS_ADDRESS[5:2]] <=
                latch_reg[I_AVS_ADDRESS[5:2]]
                & I_AVS_WRITEDATA[7:0]; // [RULE_07]
            valid_reg[I_AVS_ADDRESS[5:2]] <= 1'b1; // [RULE_02]
        end
    end

    // row address follows the most recent captured write
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            row_reg <= '0;
        end else if (arr_wr) begin
            row_reg <= I_AVS_ADDRESS[9:6]; // [RULE_03]
        end
    end

    // completion status: set wins over read clear and vector fetch
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            stat_reg <= dea_pkg::IRQ_STAT_RST;
        end else if (prog_done && ie_reg) begin
            stat_reg <= 1'b1; // [RULE_05]
        end else if (stat_rd || I_VECTOR_FETCH) begin
            stat_reg <= 1'b0; // [RULE_06]
        end
    end

    // interrupt mask
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            mask_reg <= dea_pkg::IRQ_MASK_RST;
        end else if (mask_wr) begin
            mask_reg <= I_AVS_WRITEDATA[0];
        end
    end

    // interrupt line and power-mode flags
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            irq_reg     <= 1'b0;
            ee_wait_reg <= 1'b0;
            halted_reg  <= 1'b0;
        end else begin
            irq_reg     <= stat_reg & mask_reg;
            // a running cycle finishes before wait is entered
            ee_wait_reg <= I_SLEEP_WAIT_INSTRUCTION
                           && (ps_reg == dea_pkg::PS_IDLE)
                           && !start; // [RULE_09]
            halted_reg  <= I_HALT; // [RULE_10]
        end
    end

    // outputs
    assign O_AVS_READDATA    = rdata_reg;
    assign O_AVS_WAITREQUEST = wait_reg;
    assign O_IRQ             = irq_reg;
    assign O_EE_WAIT         = ee_wait_reg;
    assign O_EE_HALTED       = halted_reg;

endmodule // dea_ctrl

// ==== dea_ctrl_assertions.sv ====
// port-level checks on the eeprom access controller
// assumes binding onto dea_ctrl; one clock, synchronous reset
`timescale 1ns/1ps
module dea_ctrl_checker #(
    parameter int ERASE_CYC = 8,
    parameter int PROG_CYC  = 8
) (
    // clock and reset
    input wire logic        I_CLK_SYS,
    input wire logic        I_SRST,
    // avalon-mm slave
    input wire logic [11:0] I_AVS_ADDRESS,
    input wire logic        I_AVS_READ,
    input wire logic        I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0]  I_AVS_BYTEENABLE,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic        O_AVS_WAITREQUEST,
    // cpu hooks and status
    input wire logic        I_VECTOR_FETCH,
    input wire logic        I_SLEEP_WAIT_INSTRUCTION,
    input wire logic        I_HALT,
    input wire logic        O_IRQ,
    input wire logic        O_EE_WAIT,
    input wire logic        O_EE_HALTED
);
    // one clock domain for every check
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SRST);

    // answers on the bus
    a_wait_one_low: assert property (
        !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
        else $error("waitrequest low longer than one cycle");
    a_read_answered: assert property (
        I_AVS_READ && O_AVS_WAITREQUEST |-> ##[1:20] !O_AVS_WAITREQUEST)
        else $error("read not answered");
    a_write_answered: assert property (
        I_AVS_WRITE && O_AVS_WAITREQUEST |-> ##[1:20] !O_AVS_WAITREQUEST)
        else $error("write not answered");
    a_data_upper_zero: assert property (
        !O_AVS_WAITREQUEST |-> O_AVS_READDATA[31:8] == 24'h000000)
        else $error("upper data set");
    a_csr_reserved_zero: assert property (
        I_AVS_READ && !O_AVS_WAITREQUEST
        && I_AVS_ADDRESS == dea_pkg::CSR_OFS |-> O_AVS_READDATA[7:3] == 5'h00)
        else $error("reserved control bits read nonzero");
    a_data_held: assert property (
        O_AVS_WAITREQUEST && $past(O_AVS_WAITREQUEST)
        |-> $stable(O_AVS_READDATA))
        else $error("read data changed idle");

    // interrupt clearing
    a_fetch_clears_irq: assert property (
        I_VECTOR_FETCH |-> ##2 !O_IRQ)
        else $error("irq still high after vector fetch");
    a_stat_read_clears: assert property (
        I_AVS_READ && !O_AVS_WAITREQUEST
        && I_AVS_ADDRESS == dea_pkg::IRQ_STAT_OFS |-> ##2 !O_IRQ)
        else $error("irq still high after status read");

    // power modes
    a_halt_seen: assert property (I_HALT |=> O_EE_HALTED)
        else $error("halt not reflected");
    a_wait_requested: assert property (O_EE_WAIT
        |-> $past(I_SLEEP_WAIT_INSTRUCTION)) else $error("wait unrequested");

    // main scenarios reached
    c_irq: cover property ($rose(O_IRQ));
    c_wait: cover property (O_EE_WAIT);
    c_halt: cover property (O_EE_HALTED);
    c_array_read: cover property (I_AVS_READ && !O_AVS_WAITREQUEST
        && I_AVS_ADDRESS[11:10] == dea_pkg::ARRAY_SEL);
endmodule // dea_ctrl_checker

bind dea_ctrl dea_ctrl_checker #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC))
    u_dea_ctrl_checker (
    .I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
    .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
    .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
    .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .I_VECTOR_FETCH(I_VECTOR_FETCH),
    .I_SLEEP_WAIT_INSTRUCTION(I_SLEEP_WAIT_INSTRUCTION), .I_HALT(I_HALT),
    .O_IRQ(O_IRQ), .O_EE_WAIT(O_EE_WAIT), .O_EE_HALTED(O_EE_HALTED));

// ==== dea_cpu_model.sv ====
// behavioural cpu bus master facing the eeprom controller
// assumes an avalon-mm slave with waitrequest on the same clock
`timescale 1ns/1ps
module dea_cpu_model (
    // clock
    input  wire logic        i_clk,
    // slave answer
    input  wire logic        i_waitrequest,
    input  wire logic [31:0] i_readdata,
    // request
    output logic      [11:0] o_address    = 12'h000,
    output logic             o_read       = 1'b0,
    output logic             o_write      = 1'b0,
    output logic      [31:0] o_writedata  = 32'h00000000,
    output logic      [3:0]  o_byteenable = 4'hF
);
    // one transfer held until waitrequest is seen low at an edge;
    // released lines carry inverted leftovers so stale values show
    task automatic access(input logic wr, input logic [11:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk);
        o_address   <= a;
        o_writedata <= {24'h000000, d};
        o_write     <= wr;
        o_read      <= ~wr;
        @(posedge i_clk);
        while (i_waitrequest !== 1'b0) @(posedge i_clk);
        q = i_readdata[7:0];
        o_write     <= 1'b0;
        o_read      <= 1'b0;
        o_address   <= ~a;
        o_writedata <= ~{24'h000000, d};
    endtask
endmodule // dea_cpu_model

// ==== tb_dea_ctrl.sv ====
// self-checking bench for the eeprom access controller
// assumes dea_ctrl, dea_cpu_model and the bound checker are compiled
`timescale 1ns/1ps
module tb_dea_ctrl;
    localparam int          ERASE_N = 8;
    localparam int          PROG_N  = 8;
    localparam logic [11:0] CSR     = dea_pkg::CSR_OFS;
    localparam logic [11:0] STAT    = dea_pkg::IRQ_STAT_OFS;
    localparam logic [11:0] MASK    = dea_pkg::IRQ_MASK_OFS;
    localparam logic [11:0] ROW     = 12'h680;  // row A of the array
    logic        clk   = 1'b0;
    logic        srst  = 1'b1;
    logic        fetch = 1'b0;
    logic        sleep = 1'b0;
    logic        halt  = 1'b0;
    logic [11:0] addr;
    logic        rd_en;
    logic        wr_en;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        waitreq;
    logic        irq;
    logic        ee_wait;
    logic        ee_halted;
    logic [7:0]  q;
    int          fail_count  = 0;
    int          check_count = 0;

    // 100 mhz system clock
    always #5 clk = ~clk;

    // controller with shortened cycle counts
    dea_ctrl #(.ERASE_CYC(ERASE_N), .PROG_CYC(PROG_N)) u_dea_ctrl (
        .I_CLK_SYS(clk), .I_SRST(srst), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd_en), .I_AVS_WRITE(wr_en), .I_AVS_WRITEDATA(wdata),
        .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(waitreq), .I_VECTOR_FETCH(fetch),
        .I_SLEEP_WAIT_INSTRUCTION(sleep), .I_HALT(halt), .O_IRQ(irq),
        .O_EE_WAIT(ee_wait), .O_EE_HALTED(ee_halted));

    // cpu side bus master
    dea_cpu_model u_dea_cpu_model (
        .i_clk(clk), .i_waitrequest(waitreq), .i_readdata(rdata),
        .o_address(addr), .o_read(rd_en), .o_write(wr_en),
        .o_writedata(wdata), .o_byteenable(be));

    // comparisons of bytes and of single bits
    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask

    // bus helpers
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        u_dea_cpu_model.access(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a);
        u_dea_cpu_model.access(1'b0, a, 8'h00, q);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_idle;
        repeat (20) begin
            rd(CSR);
            if (q[0] === 1'b0) break;
        end
        chk1("idle", 1'b0, q[0]);
    endtask

    // verdict and end of run
    task automatic finish_test;
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // reset values, reserved bits, unmapped place, start refused
    task automatic t_reset_values;
        rd(CSR);
        chk8("csr", 8'h00, q);
        rd(STAT);
        chk8("stat", {7'h00, dea_pkg::IRQ_STAT_RST}, q);
        rd(MASK);
        chk8("mask", {7'h00, dea_pkg::IRQ_MASK_RST}, q);
        rd(12'h100);
        chk8("unmapped", 8'h00, q);
        wr(CSR, 8'hF9);
        rd(CSR);
        chk8("csr_f9", 8'h00, q);
    endtask

    // capture, hidden latches, timed cycle, wait, interrupt
    task automatic t_program_cycle;
        wr(CSR, 8'h06);
        wr(ROW, 8'h5A);
        wr(ROW + 12'h014, 8'hF0);
        wr(ROW + 12'h014, 8'h3C);
        wr(ROW + 12'h03C, 8'hA5);
        rd(ROW + 12'h014);
        chk8("hidden", 8'h00, q);
        wr(CSR, 8'h07);
        sleep <= 1'b1;
        rd(CSR);
        chk8("busy", 8'h07, q);
        wr(CSR, 8'h05);
        rd(CSR);
        chk8("cap_held", 8'h07, q);
        chk1("wait_busy", 1'b0, ee_wait);
        cyc(ERASE_N + 16 + PROG_N - 14);
        rd(CSR);
        chk1("busy_late", 1'b1, q[0]);
        wait_idle;
        rd(CSR);
        chk8("done", 8'h04, q);
        chk1("irq", 1'b1, irq);
        cyc(2);
        chk1("wait_idle", 1'b1, ee_wait);
        sleep <= 1'b0;
        fetch <= 1'b1;
        cyc(1);
        fetch <= 1'b0;
        cyc(3);
        chk1("irq_fetch", 1'b0, irq);
        rd(ROW);
        chk8("b0", 8'h5A, q);
        rd(ROW + 12'h014);
        chk8("b5", 8'h30, q);
        rd(ROW + 12'h03C);
        chk8("b15", 8'hA5, q);
    endtask

    // write with capture off leaves the array alone
    task automatic t_capture_off;
        wr(ROW, 8'h00);
        rd(ROW);
        chk8("ignored", 8'h5A, q);
    endtask

    // masked interrupt, status read clears, latches start fresh
    task automatic t_masked_irq;
        wr(MASK, 8'h00);
        wr(CSR, 8'h06);
        wr(ROW + 12'h014, 8'hCF);
        wr(CSR, 8'h07);
        wait_idle;
        chk1("irq_masked", 1'b0, irq);
        wr(MASK, 8'h01);
        cyc(2);
        chk1("irq_unmask", 1'b1, irq);
        rd(STAT);
        chk8("stat_set", 8'h01, q);
        rd(STAT);
        chk8("stat_clr", 8'h00, q);
        chk1("irq_clr", 1'b0, irq);
        rd(ROW + 12'h014);
        chk8("fresh", 8'hCF, q);
    endtask

    // halt breaks a running cycle on purpose
    task automatic t_halt_abort;
        wr(CSR, 8'h06);
        wr(CSR, 8'h07);
        halt <= 1'b1;
        cyc(2);
        chk1("halted", 1'b1, ee_halted);
        rd(CSR);
        chk8("aborted", 8'h06, q);
        halt <= 1'b0;
        wr(CSR, 8'h00);
        rd(CSR);
        chk8("cap_clr", 8'h00, q);
    endtask

    // watchdog well beyond the expected run
    initial begin
        cyc(5000);
        fail_count++;
        finish_test;
    end

    // main sequence
    initial begin
        cyc(8);
        srst <= 1'b0;
        t_reset_values;
        t_program_cycle;
        t_capture_off;
        t_masked_irq;
        t_halt_abort;
        finish_test;
    end
endmodule // tb_dea_ctrl
